/* File: core/addr_arb_master.sv */
// Address-bus request, grant qualification and transfer start for one bus master
`timescale 1ns/1ps
`default_nettype none
module addr_arb_master
    import addr_arb_pkg::*;
#(
    parameter int BACKOFF_WIDTH = addr_arb_pkg::BACKOFF_W
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         reset_n_i,
    // Core request side
    input  wire logic                         req_valid_i,
    input  wire addr_arb_pkg::xfer_t          req_i,
    input  wire logic                         req_one_shot_i,
    input  wire logic                         req_cancel_i,
    output logic                              req_taken_o,
    output logic                              req_done_o,
    output logic                              req_retried_o,
    output logic                              parked_o,
    // Arbitration pins
    output logic                              bus_request_n_o,
    input  wire logic                         address_grant_n_i,
    input  wire logic                         address_retry_n_i,
    input  wire logic                         address_ack_n_i,
    // Transfer start pin
    input  wire logic                         transfer_start_n_i,
    output logic                              transfer_start_n_o,
    output logic                              transfer_start_n_oe_o,
    // Address and transfer type pins
    output logic [addr_arb_pkg::ADDR_W-1:0]   address_o,
    output logic                              address_oe_o,
    output logic [addr_arb_pkg::TTYPE_W-1:0]  transfer_type_o,
    output logic                              transfer_type_oe_o
);
    import addr_arb_pkg::*;

    // ************************************************************
    // Pin sampling
    // ************************************************************
    logic [3:0] pins_raw;
    logic [3:0] pins_lvl;
    bus_in_t    bus;

    assign pins_raw = {address_grant_n_i, address_retry_n_i,
                       address_ack_n_i, transfer_start_n_i};

    pin_filter #(
        .WIDTH     (4),
        .RESET_VAL ({4{PIN_NEGATED}})
    ) u_pin_filter (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .pin_i     (pins_raw),
        .level_o   (pins_lvl)
    );

    // Low level on a pin means asserted  [R1]
    assign bus = bus_in_t'(~pins_lvl);

    // ************************************************************
    // Bus observation
    // ************************************************************
    arb_state_t state_q;
    arb_state_t state_d;
    logic       ack_prev_q;
    logic       retry_prev_q;
    logic       grant_prev_q;
    logic       tenure_busy_q;
    logic       tenure_busy_d;
    logic       own_start;
    logic       grant_seen;

    assign own_start = (state_q == ST_START);

    // Any start opens a tenure that only ack closes  [R15]
    assign tenure_busy_d = (bus.start || own_start) ? 1'b1
                         : bus.ack ? 1'b0
                         : tenure_busy_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_prev_q    <= 1'b0;
            retry_prev_q  <= 1'b0;
            grant_prev_q  <= 1'b0;
            tenure_busy_q <= 1'b0;
        end
        else
        begin
            ack_prev_q    <= bus.ack;
            retry_prev_q  <= bus.retry;
            grant_prev_q  <= grant_seen;
            tenure_busy_q <= tenure_busy_d;
        end
    end

    // ************************************************************
    // Grant qualification
    // ************************************************************
    logic grant_window;
    logic retry_hit;
    logic grant_qual;
    logic parked;

    // Grant ignored between a start and its ack  [R13]
    assign grant_window = !tenure_busy_q && !bus.start && !own_start;

    // Only listen while idle or requesting, never mid-tenure  [R12]
    assign grant_seen = bus.grant && grant_window &&
                        ((state_q == ST_IDLE) || (state_q == ST_REQUEST));

    // Retry in the cycle following ack spoils the grant  [R9]
    assign retry_hit = ack_prev_q && bus.retry;

    // Grant held last cycle still counts on its negation  [R14]
    assign grant_qual = (grant_seen || (grant_prev_q && grant_window)) &&
                        !retry_hit && !retry_prev_q;  // [R9]

    // Grant present while not asking means the bus sits with us  [R10]
    assign parked = bus.grant && grant_window && (state_q == ST_IDLE);

    // ************************************************************
    // Back-off after grant take or retry
    // ************************************************************
    logic                     backoff_start;
    logic [BACKOFF_WIDTH-1:0] backoff_cycles;
    logic                     backoff_busy;
    logic                     take_now;
    logic                     retry_now;

    assign take_now  = (state_q == ST_IDLE || state_q == ST_REQUEST) &&
                       req_valid_i && !req_cancel_i && grant_qual;
    assign retry_now = bus.retry;

    assign backoff_start  = take_now || retry_now;
    // Both sources hold the request off for at least one cycle  [R7] [R8]
    assign backoff_cycles = retry_now ? BACKOFF_WIDTH'(RETRY_BACKOFF)
                                      : BACKOFF_WIDTH'(GRANT_BACKOFF);

    hold_timer #(
        .WIDTH     (BACKOFF_WIDTH)
    ) u_hold_timer (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .start_i   (backoff_start),
        .cycles_i  (backoff_cycles),
        .busy_o    (backoff_busy)
    );

    // ************************************************************
    // Request sequencer
    // ************************************************************
    logic may_request;

    // Withheld when retry was seen last cycle or just now  [R4] [R8]
    assign may_request = !backoff_busy && !retry_prev_q && !bus.retry;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
            begin
                if (take_now)
                begin
                    state_d = ST_START;  // [R10]
                end
                else if (req_one_shot_i && may_request && !parked)
                begin
                    state_d = ST_ONESHOT;  // [R6]
                end
                else if (req_valid_i && !req_cancel_i && may_request && !parked)
                begin
                    state_d = ST_REQUEST;  // [R2] [R5]
                end
            end
            ST_REQUEST:
            begin
                if (take_now)
                begin
                    state_d = ST_START;
                end
                else if (retry_now)
                begin
                    state_d = ST_BACKOFF;  // [R8]
                end
                else if (!req_valid_i || req_cancel_i || parked)
                begin
                    state_d = ST_IDLE;  // [R3] [R4]
                end
            end
            ST_ONESHOT:
            begin
                state_d = ST_IDLE;  // [R6]
            end
            ST_START:
            begin
                state_d = ST_ADDR;  // [R16]
            end
            ST_ADDR:
            begin
                if (bus.ack)
                begin
                    state_d = ST_CHECK;
                end
            end
            ST_CHECK:
            begin
                state_d = bus.retry ? ST_BACKOFF : ST_IDLE;
            end
            ST_BACKOFF:
            begin
                if (!backoff_busy && !retry_prev_q && !bus.retry)
                begin
                    state_d = ST_IDLE;
                end
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    logic                bus_request_n_d;
    logic                bus_request_n_q;
    logic                start_n_d;
    logic                start_n_q;
    logic                drive_d;
    logic                drive_q;
    xfer_t               xfer_q;
    xfer_t               xfer_d;

    // Asserted only while asking, and never in back-off  [R4] [R7] [R8]
    assign bus_request_n_d = ((state_d == ST_REQUEST || state_d == ST_ONESHOT) &&
                              may_request && !take_now)
                           ? PIN_ASSERTED : PIN_NEGATED;

    // Start low for the one cycle after the grant was taken  [R16]
    assign start_n_d = (state_d == ST_START) ? PIN_ASSERTED : PIN_NEGATED;

    // Drive from start through the ack cycle, float after  [R17]
    assign drive_d = (state_d == ST_START) || (state_d == ST_ADDR);

    assign xfer_d = take_now ? req_i : xfer_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_q         <= ST_IDLE;
            bus_request_n_q <= PIN_NEGATED;  // [R18]
            start_n_q       <= PIN_NEGATED;
            drive_q         <= 1'b0;
            xfer_q          <= '0;
        end
        else
        begin
            state_q         <= state_d;  // [R18]
            bus_request_n_q <= bus_request_n_d;
            start_n_q       <= start_n_d;
            drive_q         <= drive_d;
            xfer_q          <= xfer_d;
        end
    end

    assign bus_request_n_o       = bus_request_n_q;
    assign transfer_start_n_o    = start_n_q;
    assign transfer_start_n_oe_o = drive_q;
    assign address_o             = xfer_q.addr;
    assign address_oe_o          = drive_q;  // [R17]
    assign transfer_type_o       = xfer_q.ttype;
    assign transfer_type_oe_o    = drive_q;

    // ************************************************************
    // Core status
    // ************************************************************
    logic taken_q;
    logic done_q;
    logic retried_q;
    logic parked_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            taken_q   <= 1'b0;
            done_q    <= 1'b0;
            retried_q <= 1'b0;
            parked_q  <= 1'b0;
        end
        else
        begin
            taken_q   <= take_now;
            done_q    <= (state_q == ST_CHECK) && !bus.retry;
            retried_q <= (state_q == ST_CHECK) && bus.retry;
            parked_q  <= parked;
        end
    end

    assign req_taken_o   = taken_q;
    assign req_done_o    = done_q;
    assign req_retried_o = retried_q;
    assign parked_o      = parked_q;

endmodule : addr_arb_master
`default_nettype wire

/* File: core/addr_arb_pkg.sv */
// Shared types and constants for the address-bus arbitration master
// Functional notes
// R1: Active-low pins asserted low; address/type asserted high.
// R2: Request bus whenever address-bus mastership is wanted.
// R3: Request may be withdrawn without grant on cancel.
// R4: Request negated: idle, parked, or retry last cycle.
// R5: Request even with pipelined accesses outstanding.
// R6: One-cycle request for zeroing or touch-buffer load.
// R7: Request negated one cycle after taking grant.
// R8: Request negated one cycle after retry seen.
// R9: Grant qualified: grant and no retry after ack.
// R10: Parked master takes grant without requesting.
// R11: Arbiter may change grant in any cycle.
// R12: No new grant sampling until tenure completes.
// R13: Ignore grant from any transfer start to ack.
// R14: Take mastership on grant negation after valid grant.
// R15: Transfer start marks a memory address transfer.
// R16: Transfer start follows grant, lasts exactly one cycle.
// R17: Release address and start cycle after ack.
// R18: Sample on rising edge; request negated in reset.
package addr_arb_pkg;

    localparam int ADDR_W        = 32;
    localparam int TTYPE_W       = 5;
    localparam int SYNC_STAGES   = 3;
    localparam int GRANT_BACKOFF = 1;
    localparam int RETRY_BACKOFF = 1;
    localparam int BACKOFF_W     = 4;

    localparam logic PIN_NEGATED  = 1'b1;
    localparam logic PIN_ASSERTED = 1'b0;

    // Bus pins after inversion, all active high
    typedef struct packed {
        logic grant;
        logic retry;
        logic ack;
        logic start;
    } bus_in_t;

    localparam bus_in_t BUS_IDLE = '0;

    // One address transfer as the core hands it over
    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [TTYPE_W-1:0] ttype;
    } xfer_t;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_REQUEST = 3'b001,
        ST_ONESHOT = 3'b010,
        ST_START   = 3'b011,
        ST_ADDR    = 3'b100,
        ST_CHECK   = 3'b101,
        ST_BACKOFF = 3'b110
    } arb_state_t;

endpackage : addr_arb_pkg

/* File: core/pin_filter.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_filter #(
    parameter int          WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Pin side
    input  wire logic [WIDTH-1:0] pin_i,
    // Filtered level
    output logic      [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_d;
    logic [WIDTH-1:0] level_q;

    // Each bit moves once the last two stages agree
    assign level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s1_q    <= RESET_VAL;
            s2_q    <= RESET_VAL;
            s3_q    <= RESET_VAL;
            level_q <= RESET_VAL;
        end
        else
        begin
            s1_q    <= pin_i;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule : pin_filter
`default_nettype wire

/* File: core/hold_timer.sv */
// Minimum-duration hold counter
`timescale 1ns/1ps
`default_nettype none
module hold_timer #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Control
    input  wire logic             start_i,
    input  wire logic [WIDTH-1:0] cycles_i,
    // Status
    output logic                  busy_o
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    assign count_d = start_i ? cycles_i
                   : (count_q != '0) ? count_q - {{(WIDTH-1){1'b0}}, 1'b1}
                   : count_q;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            count_q <= '0;
        end
        else
        begin
            count_q <= count_d;
        end
    end

    assign busy_o = (count_q != '0);
endmodule : hold_timer
`default_nettype wire

/* File: test/addr_arb_checker.sv */
// Bound assertions for the address-bus arbitration master
`timescale 1ns/1ps
`default_nettype none
module addr_arb_checker (
    // Clock and reset
    input wire logic                        clk_i,
    input wire logic                        reset_n_i,
    // Core side
    input wire logic                        req_one_shot_i,
    input wire logic                        req_taken_o,
    input wire logic                        req_done_o,
    // Bus pins
    input wire logic                        bus_request_n_o,
    input wire logic                        address_grant_n_i,
    input wire logic                        address_retry_n_i,
    input wire logic                        address_ack_n_i,
    input wire logic                        transfer_start_n_o,
    input wire logic                        transfer_start_n_oe_o,
    input wire logic [addr_arb_pkg::ADDR_W-1:0] address_o,
    input wire logic                        address_oe_o,
    input wire logic                        transfer_type_oe_o
);
    // ********************************
    // Properties
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    start_pulse_a: assert property ($fell(transfer_start_n_o) |=> transfer_start_n_o)
        else $error("start held longer than one cycle");
    start_drive_a: assert property (!transfer_start_n_o |-> transfer_start_n_oe_o && $rose(address_oe_o))
        else $error("start outside first cycle of tenure");
    take_req_a: assert property ($fell(transfer_start_n_o) |-> bus_request_n_o && req_taken_o)
        else $error("request not dropped on take");
    oe_pair_a: assert property (address_oe_o == transfer_start_n_oe_o && address_oe_o == transfer_type_oe_o)
        else $error("drive enables disagree");
    addr_hold_a: assert property (address_oe_o && $past(address_oe_o) |-> $stable(address_o))
        else $error("address moved during tenure");
    ack_release_a: assert property (address_oe_o && !address_ack_n_i |-> ##[2:6] !address_oe_o)
        else $error("bus not released after ack");
    retry_back_a: assert property ($fell(address_retry_n_i) |-> ##[1:6] bus_request_n_o)
        else $error("request not dropped after retry");
    done_idle_a: assert property (req_done_o |-> !address_oe_o && transfer_start_n_o)
        else $error("done while still driving");
    one_shot_a: assert property (req_one_shot_i && address_grant_n_i && bus_request_n_o && !address_oe_o
        |-> ##[1:3] ($fell(bus_request_n_o) ##1 bus_request_n_o))
        else $error("one-shot request not one cycle");
    reset_out_a: assert property ($rose(reset_n_i) |-> bus_request_n_o && !address_oe_o && transfer_start_n_o)
        else $error("outputs active out of reset");

    cover property ($fell(transfer_start_n_o));
    cover property ($fell(address_retry_n_i));
    cover property (req_one_shot_i);
endmodule : addr_arb_checker

bind addr_arb_master addr_arb_checker u_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .req_one_shot_i(req_one_shot_i), .req_taken_o(req_taken_o),
    .req_done_o(req_done_o), .bus_request_n_o(bus_request_n_o), .address_grant_n_i(address_grant_n_i),
    .address_retry_n_i(address_retry_n_i), .address_ack_n_i(address_ack_n_i),
    .transfer_start_n_o(transfer_start_n_o), .transfer_start_n_oe_o(transfer_start_n_oe_o),
    .address_o(address_o), .address_oe_o(address_oe_o), .transfer_type_oe_o(transfer_type_oe_o)
);
`default_nettype wire

/* File: test/addr_arb_partner.sv */
// Behavioural system arbiter and address-phase responder
`timescale 1ns/1ps
`default_nettype none
module addr_arb_partner (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       reset_n_i,
    // Bus side
    input  wire logic       bus_request_n_i,
    input  wire logic       transfer_start_n_i,
    output logic            grant_n_o,
    output logic            ack_n_o,
    output logic            retry_n_o,
    // Scenario control
    input  wire logic       grant_en_i,
    input  wire logic       park_i,
    input  wire logic       retry_en_i,
    input  wire logic [3:0] ack_dly_i
);
    // ********************************
    // Responder
    // ********************************
    logic [4:0] ph_q;
    logic       grant_en_q;
    logic       park_q;
    logic       retry_en_q;
    logic [3:0] ack_dly_q;
    wire  [4:0] dly = {1'b0, ack_dly_q};

    // Controls settle on the rising edge, clear of the bench's falling-edge writes
    always @(posedge clk_i)
    begin
        grant_en_q <= grant_en_i;
        park_q     <= park_i;
        retry_en_q <= retry_en_i;
        ack_dly_q  <= ack_dly_i;
    end

    // Pulses span two cycles so that a filtered pin sees them
    always @(negedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            grant_n_o <= 1'b1;
            ack_n_o   <= 1'b1;
            retry_n_o <= 1'b1;
            ph_q      <= 5'h00;
        end
        else
        begin
            grant_n_o <= !(park_q || (grant_en_q && !bus_request_n_i));
            if (!transfer_start_n_i)
                ph_q <= 5'h01;
            else if (ph_q != 5'h00 && ph_q < dly + 5'h04)
                ph_q <= ph_q + 5'h01;
            else
                ph_q <= 5'h00;
            ack_n_o   <= !(ph_q >= dly && ph_q < dly + 5'h02);
            retry_n_o <= !(retry_en_q && ph_q > dly && ph_q < dly + 5'h03);
        end
    end
endmodule : addr_arb_partner
`default_nettype wire

/* File: test/address_bus_arbitration_test.sv */
// Self-checking bench for the address-bus arbitration master
`timescale 1ns/1ps
`default_nettype none
module address_bus_arbitration_test;
    import addr_arb_pkg::*;

    logic        clk_i, reset_n_i, req_valid_i, req_one_shot_i, req_cancel_i;
    xfer_t       req_i;
    logic        req_taken_o, req_done_o, req_retried_o, parked_o, bus_request_n_o;
    logic        address_grant_n_i, address_retry_n_i, address_ack_n_i;
    logic        transfer_start_n_o, transfer_start_n_oe_o, address_oe_o, transfer_type_oe_o;
    logic [31:0] address_o;
    logic [4:0]  transfer_type_o;
    logic        grant_en, park, retry_en;
    logic [3:0]  ack_dly;
    int          n_mismatch = 0;
    int          n_tests = 0;
    // Start pin as seen on the bus, pulled up when released
    wire         start_w = transfer_start_n_oe_o ? transfer_start_n_o : 1'b1;
    wire  [4:0]  obs = {bus_request_n_o, req_taken_o, req_done_o, req_retried_o, parked_o};

    addr_arb_master dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
        .req_one_shot_i(req_one_shot_i), .req_cancel_i(req_cancel_i), .req_taken_o(req_taken_o),
        .req_done_o(req_done_o), .req_retried_o(req_retried_o), .parked_o(parked_o),
        .bus_request_n_o(bus_request_n_o), .address_grant_n_i(address_grant_n_i),
        .address_retry_n_i(address_retry_n_i), .address_ack_n_i(address_ack_n_i),
        .transfer_start_n_i(start_w), .transfer_start_n_o(transfer_start_n_o),
        .transfer_start_n_oe_o(transfer_start_n_oe_o), .address_o(address_o), .address_oe_o(address_oe_o),
        .transfer_type_o(transfer_type_o), .transfer_type_oe_o(transfer_type_oe_o)
    );

    addr_arb_partner u_arb (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .bus_request_n_i(bus_request_n_o), .transfer_start_n_i(start_w),
        .grant_n_o(address_grant_n_i), .ack_n_o(address_ack_n_i), .retry_n_o(address_retry_n_i),
        .grant_en_i(grant_en), .park_i(park), .retry_en_i(retry_en), .ack_dly_i(ack_dly)
    );

    // ********************************
    // Helpers
    // ********************************
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic close_out;
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input logic [36:0] s, input logic [36:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk

    task automatic chk1(input logic s, input logic e);
        chk({36'h0, s}, {36'h0, e});
    endtask : chk1

    task automatic wt(input int b, input logic v);
        int i;
        for (i = 0; i < 60 && obs[b] !== v; i++)
            @(negedge clk_i);
        chk1(obs[b], v);
    endtask : wt

    // ********************************
    // Scenarios
    // ********************************
    task automatic s_reset;
        reset_n_i = 1'b0;
        repeat (6) @(negedge clk_i);
        chk1(bus_request_n_o, 1'b1);
        chk1(address_oe_o, 1'b0);
        reset_n_i = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask : s_reset

    task automatic s_xfer(input logic [31:0] a, input logic [4:0] t, input logic rty, input logic [3:0] d);
        ack_dly = d;
        retry_en = rty;
        req_i = '{addr: a, ttype: t};
        req_valid_i = 1'b1;
        wt(4, 1'b0);
        grant_en = 1'b1;
        wt(3, 1'b1);
        chk({address_o, transfer_type_o}, {a, t});
        chk1(transfer_start_n_o, 1'b0);
        chk1(bus_request_n_o, 1'b1);
        chk({34'h0, address_oe_o, transfer_start_n_oe_o, transfer_type_oe_o}, 37'h7);
        @(negedge clk_i);
        grant_en = 1'b0;
        chk1(transfer_start_n_o, 1'b1);
        if (rty)
        begin
            wt(1, 1'b1);
            chk1(bus_request_n_o, 1'b1);
            retry_en = 1'b0;
            grant_en = 1'b1;
            wt(3, 1'b1);
            @(negedge clk_i);
            grant_en = 1'b0;
        end
        wt(2, 1'b1);
        chk1(address_oe_o, 1'b0);
        req_valid_i = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : s_xfer

    task automatic s_one_shot;
        int lo;
        lo = 0;
        req_one_shot_i = 1'b1;
        repeat (8)
        begin
            @(negedge clk_i);
            req_one_shot_i = 1'b0;
            if (bus_request_n_o === 1'b0)
                lo++;
        end
        chk1(lo == 1, 1'b1);
    endtask : s_one_shot

    task automatic s_cancel;
        req_valid_i = 1'b1;
        wt(4, 1'b0);
        req_cancel_i = 1'b1;
        wt(4, 1'b1);
        grant_en = 1'b1;
        repeat (4) @(negedge clk_i);
        chk1(req_taken_o, 1'b0);
        req_valid_i = 1'b0;
        req_cancel_i = 1'b0;
        grant_en = 1'b0;
        repeat (3) @(negedge clk_i);
    endtask : s_cancel

    task automatic s_park;
        int i;
        int lo;
        lo = 0;
        park = 1'b1;
        repeat (6) @(negedge clk_i);
        wt(0, 1'b1);
        req_i = '{addr: 32'h0000_1000, ttype: 5'h02};
        req_valid_i = 1'b1;
        for (i = 0; i < 60 && req_taken_o !== 1'b1; i++)
        begin
            if (bus_request_n_o !== 1'b1)
                lo++;
            @(negedge clk_i);
        end
        chk1(req_taken_o, 1'b1);
        chk1(lo == 0, 1'b1);
        wt(2, 1'b1);
        req_valid_i = 1'b0;
        park = 1'b0;
        repeat (6) @(negedge clk_i);
    endtask : s_park

    // ********************************
    // Main sequence
    // ********************************
    initial
    begin
        {req_valid_i, req_one_shot_i, req_cancel_i, grant_en, park, retry_en} = 6'h00;
        req_i = '0;
        ack_dly = 4'h1;
        s_reset();
        s_one_shot();
        s_xfer(32'h8000_0004, 5'h0a, 1'b0, 4'h1);
        s_xfer(32'hffff_fff8, 5'h1f, 1'b0, 4'h5);
        s_xfer(32'h0123_4560, 5'h04, 1'b1, 4'h2);
        s_xfer(32'h0000_0000, 5'h11, 1'b0, 4'h1);
        s_cancel();
        s_park();
        req_valid_i = 1'b1;
        wt(4, 1'b0);
        s_reset();
        req_valid_i = 1'b0;
        repeat (4) @(negedge clk_i);
        close_out();
    end

    initial
    begin
        #1_000_000;
        n_mismatch++;
        close_out();
    end
endmodule : address_bus_arbitration_test
`default_nettype wire
